// ---- design/adcci_consts.svh ----
// register indices, field positions, window modes, reset values and bus answers for the conversion control block
`ifndef ADCCI_CONSTS_SVH
`define ADCCI_CONSTS_SVH

// register indices; the byte address on the bus is four times the index
`define ADCCI_IDX_CONTROL      6'h00
`define ADCCI_IDX_WINDOW_MODE  6'h04
`define ADCCI_IDX_COMMAND      6'h08
`define ADCCI_IDX_EVENT_CTRL   6'h09
`define ADCCI_IDX_INT_ENABLE   6'h0a
`define ADCCI_IDX_INT_FLAGS    6'h0b
`define ADCCI_IDX_RESULT       6'h10
`define ADCCI_IDX_WIN_LOW      6'h12
`define ADCCI_IDX_WIN_HIGH     6'h14

// field positions
`define ADCCI_BIT_FREE_RUN     0
`define ADCCI_BIT_START        0
`define ADCCI_BIT_EVENT_EN     0
`define ADCCI_BIT_RESULT_READY 0
`define ADCCI_BIT_WINDOW_MATCH 1

// window mode encodings
`define ADCCI_WIN_NONE         3'h0
`define ADCCI_WIN_BELOW        3'h1
`define ADCCI_WIN_ABOVE        3'h2
`define ADCCI_WIN_INSIDE       3'h3
`define ADCCI_WIN_OUTSIDE      3'h4

// reset values
`define ADCCI_RST_BYTE         8'h00
`define ADCCI_RST_WORD         16'h0000

// bus answers
`define ADCCI_RESP_OKAY        2'h0
`define ADCCI_RESP_SLVERR      2'h2

`endif

// ---- design/adcci_pkg.sv ----
// types shared by the conversion control block and its bench
package adcci_pkg;

  typedef enum logic {
    adcci_idle,
    adcci_busy
  } adcci_state_type;

  // end-of-conversion report from the converter core
  typedef struct packed {
    logic        done;
    logic [15:0] value;
  } adcci_result_type;

  typedef struct packed {
    logic        free_run;
    logic [2:0]  window_mode;
    logic        event_en;
    logic [1:0]  int_enable;
    logic [1:0]  int_flags;
    logic [15:0] result;
    logic [15:0] win_low;
    logic [15:0] win_high;
  } adcci_regs_type;

endpackage : adcci_pkg

// ---- design/adcci_top.sv ----
// conversion command, event trigger and interrupt logic with an AXI4-Lite register slave
//
// Summary of operation
// - writing one to the start bit begins one conversion
// - in free-running mode that write launches only the first of the series
// - start bit reads one while converting, cleared by hardware at completion unless free-running mode is set
// - with event enable set an event starts a conversion; otherwise ignored
// - interrupt enable bit 1 enables the window match request
// - interrupt enable bit 0 enables the result ready request
// - window match flag, bit 1, set at completion when result meets mode
// - window comparison evaluated once, at the end of each conversion
// - window flag cleared by writing one, reading result or reading flags; zero no effect
// - result ready flag, bit 0, set whenever a conversion completes
// - result flag cleared by writing one, reading result or reading flags; zero no effect
// - window modes: none, below, above, strictly inside, outside; others reserved
// - thresholds compare the final accumulated value, never single samples
`include "adcci_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module adcci_top (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic [7:0]                s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output var  logic                      s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output var  logic                      s_axi_wready,
  output var  logic [1:0]                s_axi_bresp,
  output var  logic                      s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [7:0]                s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output var  logic                      s_axi_arready,
  output var  logic [31:0]               s_axi_rdata,
  output var  logic [1:0]                s_axi_rresp,
  output var  logic                      s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic                      start_event,
  input  wire adcci_pkg::adcci_result_type conv_report,
  output var  logic                      conv_start,
  output var  logic                      conv_busy,
  output var  logic                      irq_result_ready,
  output var  logic                      irq_window_match,
  output var  logic                      irq
);

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction : merge16

  // thresholds and result share one format; reserved modes never match
  function automatic logic window_hit(input logic [2:0]  mode,
                                      input logic [15:0] value,
                                      input logic [15:0] low,
                                      input logic [15:0] high);
    logic hit;
    hit = 1'b0;
    case (mode)
      `ADCCI_WIN_BELOW:   hit = value < low;
      `ADCCI_WIN_ABOVE:   hit = value > high;
      `ADCCI_WIN_INSIDE:  hit = (value > low) && (value < high);
      `ADCCI_WIN_OUTSIDE: hit = (value < low) || (value > high);
      default:            hit = 1'b0;
    endcase
    return hit;
  endfunction : window_hit

  // one decode serves both bus directions, so writes and reads refuse the same holes
  function automatic logic reg_mapped(input logic [5:0] index);
    logic hit;
    hit = 1'b0;
    case (index)
      `ADCCI_IDX_CONTROL,
      `ADCCI_IDX_WINDOW_MODE,
      `ADCCI_IDX_COMMAND,
      `ADCCI_IDX_EVENT_CTRL,
      `ADCCI_IDX_INT_ENABLE,
      `ADCCI_IDX_INT_FLAGS,
      `ADCCI_IDX_RESULT,
      `ADCCI_IDX_WIN_LOW,
      `ADCCI_IDX_WIN_HIGH: hit = 1'b1;
      default:             hit = 1'b0;
    endcase
    return hit;
  endfunction : reg_mapped

  adcci_pkg::adcci_state_type state;
  adcci_pkg::adcci_state_type next_state;
  adcci_pkg::adcci_regs_type  regs;
  adcci_pkg::adcci_regs_type  next_regs;

  logic        aw_held;
  logic        w_held;
  logic [5:0]  aw_index;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        next_aw_held;
  logic        next_w_held;
  logic [5:0]  next_aw_index;
  logic [31:0] next_w_data;
  logic [3:0]  next_w_strb;

  logic        next_awready;
  logic        next_wready;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_arready;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic        next_conv_start;
  logic        next_conv_busy;
  logic        next_irq_result_ready;
  logic        next_irq_window_match;
  logic        next_irq;

  always_comb begin
    logic [5:0] rd_index;
    logic       sw_start;
    logic       ev_start;
    logic [1:0] flag_clear;
    logic [1:0] flag_set;
    rd_index   = s_axi_araddr[7:2];
    sw_start   = 1'b0;
    ev_start   = 1'b0;
    flag_clear = 2'b00;
    flag_set   = 2'b00;

    next_state            = state;
    next_regs             = regs;
    next_aw_held          = aw_held;
    next_w_held           = w_held;
    next_aw_index         = aw_index;
    next_w_data           = w_data;
    next_w_strb           = w_strb;
    next_awready          = s_axi_awready;
    next_wready           = s_axi_wready;
    next_bvalid           = s_axi_bvalid;
    next_bresp            = s_axi_bresp;
    next_arready          = s_axi_arready;
    next_rvalid           = s_axi_rvalid;
    next_rdata            = s_axi_rdata;
    next_rresp            = s_axi_rresp;
    next_conv_start       = 1'b0;

    // write address and data are taken in either order and held until both are present
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held  = 1'b1;
      next_aw_index = s_axi_awaddr[7:2];
      next_awready  = 1'b0;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
      next_wready = 1'b0;
    end

    if (aw_held && w_held && !s_axi_bvalid) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = reg_mapped(aw_index) ? `ADCCI_RESP_OKAY : `ADCCI_RESP_SLVERR;
      case (aw_index)
        `ADCCI_IDX_CONTROL: begin
          if (w_strb[0]) begin
            next_regs.free_run = w_data[`ADCCI_BIT_FREE_RUN];
          end
        end
        `ADCCI_IDX_WINDOW_MODE: begin
          if (w_strb[0]) begin
            next_regs.window_mode = w_data[2:0];
          end
        end
        `ADCCI_IDX_COMMAND: begin
          // a zero cannot abort; a one while busy is ignored
          sw_start = w_strb[0] && w_data[`ADCCI_BIT_START];
        end
        `ADCCI_IDX_EVENT_CTRL: begin
          if (w_strb[0]) begin
            next_regs.event_en = w_data[`ADCCI_BIT_EVENT_EN];
          end
        end
        `ADCCI_IDX_INT_ENABLE: begin
          if (w_strb[0]) begin
            next_regs.int_enable = w_data[1:0];
          end
        end
        `ADCCI_IDX_INT_FLAGS: begin
          if (w_strb[0]) begin
            flag_clear = flag_clear | w_data[1:0];
          end
        end
        `ADCCI_IDX_RESULT: begin
        end
        `ADCCI_IDX_WIN_LOW: begin
          next_regs.win_low = merge16(regs.win_low, w_data, w_strb);
        end
        `ADCCI_IDX_WIN_HIGH: begin
          next_regs.win_high = merge16(regs.win_high, w_data, w_strb);
        end
        default: begin
          // refused: nothing is written
        end
      endcase
    end

    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid  = 1'b0;
      next_awready = 1'b1;
      next_wready  = 1'b1;
    end

    if (s_axi_arvalid && s_axi_arready) begin
      next_arready = 1'b0;
      next_rvalid  = 1'b1;
      next_rresp   = reg_mapped(rd_index) ? `ADCCI_RESP_OKAY : `ADCCI_RESP_SLVERR;
      next_rdata   = 32'h0000_0000;
      case (rd_index)
        `ADCCI_IDX_CONTROL:     next_rdata[0] = regs.free_run;
        `ADCCI_IDX_WINDOW_MODE: next_rdata[2:0] = regs.window_mode;
        `ADCCI_IDX_COMMAND:     next_rdata[0] = (state == adcci_pkg::adcci_busy);
        `ADCCI_IDX_EVENT_CTRL:  next_rdata[0] = regs.event_en;
        `ADCCI_IDX_INT_ENABLE:  next_rdata[1:0] = regs.int_enable;
        `ADCCI_IDX_INT_FLAGS: begin
          next_rdata[1:0] = regs.int_flags;
          flag_clear      = flag_clear | 2'b11;
        end
        `ADCCI_IDX_RESULT: begin
          next_rdata[15:0] = regs.result;
          flag_clear       = flag_clear | 2'b11;
        end
        `ADCCI_IDX_WIN_LOW:     next_rdata[15:0] = regs.win_low;
        `ADCCI_IDX_WIN_HIGH:    next_rdata[15:0] = regs.win_high;
        default:                next_rdata = 32'h0000_0000;
      endcase
    end

    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid  = 1'b0;
      next_arready = 1'b1;
    end

    ev_start = start_event && regs.event_en;

    unique case (state)
      adcci_pkg::adcci_idle: begin
        if (sw_start || ev_start) begin
          next_state      = adcci_pkg::adcci_busy;
          next_conv_start = 1'b1;
        end
      end
      adcci_pkg::adcci_busy: begin
        if (conv_report.done) begin
          // the report carries the finished accumulation, so the window sees only that
          next_regs.result = conv_report.value;
          flag_set[`ADCCI_BIT_RESULT_READY] = 1'b1;
          flag_set[`ADCCI_BIT_WINDOW_MATCH] = window_hit(regs.window_mode,
                                                         conv_report.value,
                                                         regs.win_low,
                                                         regs.win_high);
          if (regs.free_run) begin
            next_conv_start = 1'b1;
          end else begin
            next_state = adcci_pkg::adcci_idle;
          end
        end
      end
    endcase

    // a completion in the clearing cycle is not lost: set wins
    next_regs.int_flags = (regs.int_flags & ~flag_clear) | flag_set;

    next_irq_result_ready = next_regs.int_flags[0] && next_regs.int_enable[0];
    next_irq_window_match = next_regs.int_flags[1] && next_regs.int_enable[1];
    next_irq              = next_irq_result_ready || next_irq_window_match;

    // a free channel offers ready again; readies rise one cycle after reset release
    next_awready   = next_awready || (!aw_held && !next_aw_held && !next_bvalid);
    next_wready    = next_wready || (!w_held && !next_w_held && !next_bvalid);
    next_arready   = next_arready || !next_rvalid;
    next_conv_busy = (next_state == adcci_pkg::adcci_busy);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state            <= adcci_pkg::adcci_idle;
      regs             <= '0;
      aw_held          <= 1'b0;
      w_held           <= 1'b0;
      aw_index         <= 6'h00;
      w_data           <= 32'h0000_0000;
      w_strb           <= 4'h0;
      s_axi_awready    <= 1'b0;
      s_axi_wready     <= 1'b0;
      s_axi_bvalid     <= 1'b0;
      s_axi_bresp      <= `ADCCI_RESP_OKAY;
      s_axi_arready    <= 1'b0;
      s_axi_rvalid     <= 1'b0;
      s_axi_rdata      <= 32'h0000_0000;
      s_axi_rresp      <= `ADCCI_RESP_OKAY;
      conv_start       <= 1'b0;
      conv_busy        <= 1'b0;
      irq_result_ready <= 1'b0;
      irq_window_match <= 1'b0;
      irq              <= 1'b0;
    end else begin
      state            <= next_state;
      regs             <= next_regs;
      aw_held          <= next_aw_held;
      w_held           <= next_w_held;
      aw_index         <= next_aw_index;
      w_data           <= next_w_data;
      w_strb           <= next_w_strb;
      s_axi_awready    <= next_awready;
      s_axi_wready     <= next_wready;
      s_axi_bvalid     <= next_bvalid;
      s_axi_bresp      <= next_bresp;
      s_axi_arready    <= next_arready;
      s_axi_rvalid     <= next_rvalid;
      s_axi_rdata      <= next_rdata;
      s_axi_rresp      <= next_rresp;
      conv_start       <= next_conv_start;
      conv_busy        <= next_conv_busy;
      irq_result_ready <= next_irq_result_ready;
      irq_window_match <= next_irq_window_match;
      irq              <= next_irq;
    end
  end

endmodule : adcci_top

`default_nettype wire

// ---- tb/adc_conversion_command_irq_tb.sv ----
// self-checking bench for the conversion control block
`include "adcci_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module adc_conversion_command_irq_tb;
  typedef struct packed {
    logic [2:0]  mode;
    logic [15:0] value;
    logic        hit;
  } adcci_row_type;
  logic                        clk = 1'b0;
  logic                        rst = 1'b1;
  logic [7:0]                  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]                 s_axi_wdata = 32'h0, s_axi_rdata, rdat;
  logic [3:0]                  s_axi_wstrb = 4'hf;
  logic                        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic                        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, start_event = 1'b0;
  logic                        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic                        s_axi_rvalid, conv_start, conv_busy, irq;
  logic                        irq_result_ready, irq_window_match;
  logic [1:0]                  s_axi_bresp, s_axi_rresp, resp;
  adcci_pkg::adcci_result_type conv_report = '0;
  int                          errors = 0, total_checks = 0, starts = 0, s;
  // thresholds are 0x0100 and 0x0200; equal values sit on the strict edges
  adcci_row_type               rows [10] = '{'{3'h0, 16'h0050, 1'b0}, '{3'h1, 16'h00ff, 1'b1},
    '{3'h1, 16'h0100, 1'b0}, '{3'h2, 16'h0201, 1'b1}, '{3'h2, 16'h0200, 1'b0},
    '{3'h3, 16'h0101, 1'b1}, '{3'h3, 16'h0200, 1'b0}, '{3'h4, 16'h0050, 1'b1},
    '{3'h4, 16'h0150, 1'b0}, '{3'h5, 16'h0050, 1'b0}};

  always #2 clk = ~clk;
  always @(posedge clk) if (conv_start === 1'b1) starts <= starts + 1;

  adcci_top i_dut (.*);

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // each bus task ends off the edge so a following call never reassigns in one step
  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [5:0] idx);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    #1;
  endtask : rd

  task automatic conv_done(input logic [15:0] v);
    @(posedge clk);
    conv_report <= {1'b1, v};
    @(posedge clk);
    conv_report.done <= 1'b0;
    #1;
  endtask : conv_done

  task automatic pulse_event();
    @(posedge clk);
    start_event <= 1'b1;
    @(posedge clk);
    start_event <= 1'b0;
    #1;
  endtask : pulse_event

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    report_and_stop();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    wr(`ADCCI_IDX_EVENT_CTRL, 1);
    wr(`ADCCI_IDX_INT_ENABLE, 3);
    wr(`ADCCI_IDX_WIN_LOW, 32'h100);
    wr(`ADCCI_IDX_WIN_HIGH, 32'h200);
    foreach (rows[i]) begin
      wr(`ADCCI_IDX_WINDOW_MODE, rows[i].mode);
      if (i % 2) pulse_event();
      else wr(`ADCCI_IDX_COMMAND, 1);
      chk("busy", 1, conv_busy);
      conv_done(rows[i].value);
      chk("irq_rr", 1, irq_result_ready);
      chk("irq_wm", rows[i].hit, irq_window_match);
      chk("busy_end", 0, conv_busy);
      rd(`ADCCI_IDX_RESULT);
      chk("result", rows[i].value, rdat);
      chk("irq_clr", 0, irq);
    end
    $display("window table done");
    wr(`ADCCI_IDX_COMMAND, 1);
    rd(`ADCCI_IDX_COMMAND);
    chk("start_bit", 1, rdat);
    s = starts;
    wr(`ADCCI_IDX_COMMAND, 0);
    pulse_event();
    chk("no_restart", s, starts);
    conv_done(16'h0000);
    rd(`ADCCI_IDX_COMMAND);
    chk("start_clr", 0, rdat);
    $display("start bit done");
    wr(`ADCCI_IDX_WINDOW_MODE, `ADCCI_WIN_OUTSIDE);
    wr(`ADCCI_IDX_COMMAND, 1);
    conv_done(16'h0000);
    wr(`ADCCI_IDX_INT_FLAGS, 0);
    chk("w0", 2'h3, {irq_window_match, irq_result_ready});
    wr(`ADCCI_IDX_INT_FLAGS, 2);
    chk("w1c_wm", 2'h1, {irq_window_match, irq_result_ready});
    wr(`ADCCI_IDX_INT_FLAGS, 1);
    chk("w1c_rr", 0, irq_result_ready);
    wr(`ADCCI_IDX_COMMAND, 1);
    conv_done(16'h0000);
    wr(`ADCCI_IDX_INT_ENABLE, 1);
    chk("en_rr", 2'h1, {irq_window_match, irq_result_ready});
    chk("irq_on", 1, irq);
    wr(`ADCCI_IDX_INT_ENABLE, 2);
    chk("en_wm", 2'h2, {irq_window_match, irq_result_ready});
    wr(`ADCCI_IDX_INT_ENABLE, 0);
    chk("masked", 0, irq);
    rd(`ADCCI_IDX_INT_FLAGS);
    chk("flags_rd", 2'h3, rdat);
    rd(`ADCCI_IDX_INT_FLAGS);
    chk("flags_rd_clr", 0, rdat);
    s_axi_wstrb <= 4'h1;
    wr(`ADCCI_IDX_WIN_LOW, 32'h0000_55aa);
    s_axi_wstrb <= 4'hf;
    rd(`ADCCI_IDX_WIN_LOW);
    chk("lane", 32'h0000_01aa, rdat);
    $display("flags done");
    wr(`ADCCI_IDX_EVENT_CTRL, 0);
    pulse_event();
    chk("ev_off", 0, conv_busy);
    rd(6'h3f);
    chk("rd_unmapped", `ADCCI_RESP_SLVERR, resp);
    wr(6'h3f, 1);
    chk("wr_unmapped", `ADCCI_RESP_SLVERR, resp);
    wr(`ADCCI_IDX_CONTROL, 1);
    wr(`ADCCI_IDX_COMMAND, 1);
    s = starts;
    conv_done(16'h0005);
    repeat (2) @(posedge clk);
    #1;
    chk("free_busy", 1, conv_busy);
    chk("free_next", s + 1, starts);
    wr(`ADCCI_IDX_CONTROL, 0);
    conv_done(16'h0006);
    chk("free_stop", 0, conv_busy);
    $display("event and free run done");
    wr(`ADCCI_IDX_EVENT_CTRL, 1);
    wr(`ADCCI_IDX_INT_ENABLE, 3);
    wr(`ADCCI_IDX_COMMAND, 1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("rst_busy", 0, conv_busy);
    for (int k = 8; k < 12; k++) begin
      rd(k[5:0]);
      chk("rst_reg", 0, rdat);
    end
    $display("reset done");
    report_and_stop();
  end
endmodule : adc_conversion_command_irq_tb
`default_nettype wire

// ---- tb/adcci_monitor.sv ----
// concurrent checks on the conversion control block ports
`include "adcci_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module adcci_monitor (
  input wire logic                        clk,
  input wire logic                        rst,
  input wire logic [7:0]                  s_axi_awaddr,
  input wire logic                        s_axi_awvalid,
  input wire logic                        s_axi_awready,
  input wire logic [31:0]                 s_axi_wdata,
  input wire logic [3:0]                  s_axi_wstrb,
  input wire logic                        s_axi_wvalid,
  input wire logic                        s_axi_wready,
  input wire logic                        s_axi_bvalid,
  input wire logic [7:0]                  s_axi_araddr,
  input wire logic                        s_axi_arvalid,
  input wire logic                        s_axi_arready,
  input wire logic                        s_axi_rvalid,
  input wire adcci_pkg::adcci_result_type conv_report,
  input wire logic                        conv_start,
  input wire logic                        conv_busy,
  input wire logic                        irq_result_ready,
  input wire logic                        irq_window_match,
  input wire logic                        irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_aw_w;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_ar;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_w1c;
    s_aw_w ##0 (s_axi_awaddr[7:2] == `ADCCI_IDX_INT_FLAGS && s_axi_wdata[0] && s_axi_wstrb[0]);
  endsequence
  sequence s_res_rd;
    s_ar ##0 (s_axi_araddr[7:2] == `ADCCI_IDX_RESULT && !conv_report.done);
  endsequence
  property p_start_busy; conv_start |-> conv_busy; endproperty
  a_start_busy: assert property (p_start_busy) else $error("start without busy");
  property p_busy_rise; $rose(conv_busy) |-> conv_start; endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy without start");
  property p_busy_holds; conv_busy && !conv_report.done |=> conv_busy; endproperty
  a_busy_holds: assert property (p_busy_holds) else $error("busy dropped early");
  // free-running restarts instead of going idle
  property p_done_ends; conv_busy && conv_report.done |-> ##[1:2] (conv_start || !conv_busy);
  endproperty
  a_done_ends: assert property (p_done_ends) else $error("no end or restart");
  property p_no_restart;
    conv_busy && !conv_report.done && !$past(conv_report.done) |=> !conv_start;
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("start while busy");
  property p_irq_or; irq == (irq_result_ready || irq_window_match); endproperty
  a_irq_or: assert property (p_irq_or) else $error("irq not the or");
  property p_res_clr; s_res_rd |=> !irq_result_ready && !irq_window_match; endproperty
  a_res_clr: assert property (p_res_clr) else $error("result read kept flags");
  property p_w1c; s_w1c ##1 !conv_report.done |=> !irq_result_ready; endproperty
  a_w1c: assert property (p_w1c) else $error("write one kept flag");
  property p_rd_ans; s_ar |-> ##1 s_axi_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_wr_ans; s_aw_w |-> ##2 s_axi_bvalid; endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
endmodule : adcci_monitor
bind adcci_top adcci_monitor i_mon (.*);
`default_nettype wire
